// ---- logic/short_flag_pkg.sv ----
package short_flag_pkg;

	localparam int ADDR_W       = 12;
	localparam int DATA_W       = 32;
	localparam int STRB_W       = DATA_W / 8;
	localparam int CH_PER_GROUP = 3;
	localparam int NUM_GROUPS   = 4;
	localparam int NUM_FLAGS    = CH_PER_GROUP * NUM_GROUPS;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FLAGS_CD = 8'hA4;
	localparam logic [7:0] IDX_FLAGS_EF = 8'hA5;
	localparam logic [7:0] IDX_FLAGS_GH = 8'hA6;
	localparam logic [7:0] IDX_MASK     = 8'hB0;
	localparam logic [7:0] IDX_CTRL     = 8'hB1;
	localparam logic [7:0] IDX_SUMMARY  = 8'hB2;

	localparam logic [ADDR_W-1:0] ADDR_FLAGS_CD = {2'b00, IDX_FLAGS_CD, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_EF = {2'b00, IDX_FLAGS_EF, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FLAGS_GH = {2'b00, IDX_FLAGS_GH, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_MASK     = {2'b00, IDX_MASK, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = {2'b00, IDX_CTRL, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_SUMMARY  = {2'b00, IDX_SUMMARY, 2'b00};

	// field positions inside one flag byte
	localparam int HI_GRP_LSB = 4;
	localparam int LO_GRP_LSB = 0;
	localparam int RSVD_HI    = 7;
	localparam int RSVD_LO    = 3;

	// flag vector layout: group c lowest
	localparam int GRP_C_LSB = 0;
	localparam int GRP_D_LSB = 3;
	localparam int GRP_E_LSB = 6;
	localparam int GRP_F_LSB = 9;

	localparam int CTRL_LATCH_BIT = 0;
	localparam int CTRL_CLEAR_BIT = 1;

	localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 12'h000;
	localparam logic [NUM_FLAGS-1:0] MASK_RESET  = 12'hFFF;
	localparam logic                 LATCH_RESET = 1'b0;
	localparam logic [7:0]           BYTE_ZERO   = 8'h00;

	typedef struct packed {
		logic [2:0] grp_f;
		logic [2:0] grp_e;
		logic [2:0] grp_d;
		logic [2:0] grp_c;
	} short_detect_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} apb_resp_t;

endpackage

// ---- logic/short_sync.sv ----
module short_sync #(
	parameter int WIDTH = 12
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stage_reg;

	// the first stage feeds only the second
	for (genvar gi = 0; gi < WIDTH; gi++) begin : g_bit
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_reg[gi]  <= 1'b0;
				stage_reg[gi] <= 1'b0;
			end else begin
				meta_reg[gi]  <= async_in[gi];
				stage_reg[gi] <= meta_reg[gi];
			end
		end
	end

	assign sync_out = stage_reg;

endmodule

// ---- logic/short_led_flag_regs.sv ----
module short_led_flag_regs
	import short_flag_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [DATA_W-1:0]   pwdata,
	input  wire logic [STRB_W-1:0]   pstrb,
	input  wire short_detect_t       short_detect,
	output logic      [DATA_W-1:0]   prdata,
	output logic                     pready,
	output logic                     pslverr
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	logic [NUM_FLAGS-1:0] det_bits;
	logic [NUM_FLAGS-1:0] det_live;
	logic [NUM_FLAGS-1:0] flag_reg;
	logic [NUM_FLAGS-1:0] flag_next;
	logic [NUM_FLAGS-1:0] mask_reg;
	logic [NUM_FLAGS-1:0] mask_next;
	logic                 latch_reg;
	logic                 latch_next;
	logic                 clr;
	apb_resp_t            resp_reg;
	apb_resp_t            resp_next;
	logic                 access_done;
	logic                 wr_done;
	logic                 rd_done;
	logic                 flag_addr;
	logic                 mapped;
	logic [DATA_W-1:0]    rd_word;
	logic                 rst_seen_reg;

	function automatic logic [DATA_W-1:0] pack_pair(input logic [2:0] hi, input logic [2:0] lo);
		logic [7:0] b;
		b = BYTE_ZERO;
		b[HI_GRP_LSB +: CH_PER_GROUP] = hi;
		b[LO_GRP_LSB +: CH_PER_GROUP] = lo;
		return {{(DATA_W-8){1'b0}}, b};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// detect inputs come from analog diagnostics, hence the synchroniser

	short_sync #(
		.WIDTH (NUM_FLAGS)
	) u_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in (short_detect),
		.sync_out (det_bits)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake

	assign access_done = psel && penable && resp_reg.pready;
	assign wr_done     = access_done && pwrite;
	assign rd_done     = access_done && !pwrite;
	assign flag_addr   = (paddr == ADDR_FLAGS_CD) || (paddr == ADDR_FLAGS_EF) || (paddr == ADDR_FLAGS_GH);

	always_comb begin
		rd_word = '0;
		mapped  = 1'b1;
		if (paddr == ADDR_FLAGS_CD) begin
			rd_word = pack_pair(flag_reg[GRP_D_LSB +: CH_PER_GROUP],
			                    flag_reg[GRP_C_LSB +: CH_PER_GROUP]);
		end else if (paddr == ADDR_FLAGS_EF) begin
			rd_word = pack_pair(flag_reg[GRP_F_LSB +: CH_PER_GROUP],
			                    flag_reg[GRP_E_LSB +: CH_PER_GROUP]);
		end else if (paddr == ADDR_FLAGS_GH) begin
			// groups g and h are not wired into this bank
			rd_word = {{(DATA_W-8){1'b0}}, BYTE_ZERO};
		end else if (paddr == ADDR_MASK) begin
			rd_word = {{(DATA_W-NUM_FLAGS){1'b0}}, mask_reg};
		end else if (paddr == ADDR_CTRL) begin
			rd_word[CTRL_LATCH_BIT] = latch_reg;
		end else if (paddr == ADDR_SUMMARY) begin
			rd_word[0] = |flag_reg[GRP_C_LSB +: CH_PER_GROUP];
			rd_word[1] = |flag_reg[GRP_D_LSB +: CH_PER_GROUP];
			rd_word[2] = |flag_reg[GRP_E_LSB +: CH_PER_GROUP];
			rd_word[3] = |flag_reg[GRP_F_LSB +: CH_PER_GROUP];
		end else begin
			mapped = 1'b0;
		end
	end

	// one wait state: ready is registered, so every access is three cycles, setup included
	always_comb begin
		resp_next = '0;
		if (psel && penable && !resp_reg.pready) begin
			resp_next.pready  = 1'b1;
			resp_next.pslverr = !mapped;
			resp_next.prdata  = pwrite ? '0 : rd_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_reg <= '0;
		end else begin
			resp_reg <= resp_next;
		end
	end

	assign prdata  = resp_reg.prdata;
	assign pready  = resp_reg.pready;
	assign pslverr = resp_reg.pslverr;

	////////////////////////////////////////////////////////////////////////////////
	// software control; writes to the flag registers fall through untouched

	always_comb begin
		mask_next  = mask_reg;
		latch_next = latch_reg;
		clr        = 1'b0;
		if (wr_done && paddr == ADDR_MASK) begin
			if (pstrb[0]) begin
				mask_next[7:0] = pwdata[7:0];
			end
			if (pstrb[1]) begin
				mask_next[NUM_FLAGS-1:8] = pwdata[NUM_FLAGS-1:8];
			end
		end else if (wr_done && paddr == ADDR_CTRL && pstrb[0]) begin
			latch_next = pwdata[CTRL_LATCH_BIT];
			clr        = pwdata[CTRL_CLEAR_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg  <= MASK_RESET;
			latch_reg <= LATCH_RESET;
		end else begin
			mask_reg  <= mask_next;
			latch_reg <= latch_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flag state; in latch mode a detect in the clear cycle still sets the flag

	for (genvar gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
		assign det_live[gi]  = det_bits[gi] && mask_reg[gi];
		assign flag_next[gi] = latch_reg ? (det_live[gi] || (flag_reg[gi] && !clr))
		                                 : det_live[gi];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= FLAGS_RESET;
		end else begin
			flag_reg <= flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_seen_reg <= 1'b0;
		end else begin
			rst_seen_reg <= 1'b1;
		end
	end

	a_cd_high_field: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_FLAGS_CD) |->
		(prdata[HI_GRP_LSB +: CH_PER_GROUP] == $past(flag_reg[GRP_D_LSB +: CH_PER_GROUP])))
		else $error("cd read: group d field wrong");

	a_cd_low_field: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_FLAGS_CD) |->
		(prdata[LO_GRP_LSB +: CH_PER_GROUP] == $past(flag_reg[GRP_C_LSB +: CH_PER_GROUP])) && !pslverr)
		else $error("cd read: group c field wrong");

	a_ef_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(access_done && paddr == ADDR_FLAGS_EF) |-> !pslverr)
		else $error("ef register answered with error");

	a_ef_fields: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_FLAGS_EF) |->
		(prdata[HI_GRP_LSB +: CH_PER_GROUP] == $past(flag_reg[GRP_F_LSB +: CH_PER_GROUP])) &&
		(prdata[LO_GRP_LSB +: CH_PER_GROUP] == $past(flag_reg[GRP_E_LSB +: CH_PER_GROUP])))
		else $error("ef read: group fields wrong");

	a_detect_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(det_live != '0) |=> ((flag_reg & $past(det_live)) == $past(det_live)))
		else $error("detected short not reported");

	a_live_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(!latch_reg && !latch_next) |=> (flag_reg == $past(det_live)))
		else $error("live flag does not follow detect");

	a_reset_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!rst_seen_reg |-> (flag_reg == FLAGS_RESET))
		else $error("flags not zero after reset");

	a_gh_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_FLAGS_GH) |-> (prdata == '0) && !pslverr)
		else $error("gh read not zero");

	a_cd_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		(access_done && paddr == ADDR_FLAGS_CD) |-> !pslverr)
		else $error("cd register answered with error");

	a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && flag_addr) |->
		!prdata[RSVD_HI] && !prdata[RSVD_LO] && (prdata[DATA_W-1:8] == '0))
		else $error("reserved flag bits not zero");

	a_ro_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_done && flag_addr) |=> $stable(mask_reg) && $stable(latch_reg) && !$past(pslverr))
		else $error("write to flag register had an effect");

	a_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("ready not given after one wait state");

	a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(access_done && !$past(mapped)) |-> pslverr)
		else $error("unmapped access without error");

	////////////////////////////////////////////////////////////////////////////////
	// extras: mask, latch, clear, summary and bus timing

	a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_done && paddr == ADDR_MASK && pstrb[0] && pstrb[1]) |=>
		(mask_reg == $past(pwdata[NUM_FLAGS-1:0])))
		else $error("mask write not taken");

	a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_done && paddr == ADDR_CTRL && pstrb[0]) |=> (latch_reg == $past(pwdata[CTRL_LATCH_BIT])))
		else $error("latch mode write not taken");

	a_strb_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_done && paddr == ADDR_CTRL && !pstrb[0]) |=> $stable(latch_reg))
		else $error("ctrl write without strobe had an effect");

	a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_reg && !clr) |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg)))
		else $error("latched flag lost without clear");

	// set beats clear, so a short in the clear cycle is never lost
	a_clear_drops: assert property (@(posedge pclk) disable iff (!presetn)
		(latch_reg && clr) |=> (flag_reg == $past(det_live)))
		else $error("clear did not leave only live detects");

	a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!latch_reg |=> ((flag_reg & ~$past(mask_reg)) == '0))
		else $error("masked channel flagged in live mode");

	a_mask_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_MASK) |-> (prdata == {{(DATA_W-NUM_FLAGS){1'b0}}, $past(mask_reg)}))
		else $error("mask read wrong");

	a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_CTRL) |->
		(prdata[DATA_W-1:1] == '0) && (prdata[CTRL_LATCH_BIT] == $past(latch_reg)))
		else $error("ctrl read wrong");

	a_summary_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_done && paddr == ADDR_SUMMARY) |->
		(prdata[DATA_W-1:4] == '0) &&
		(prdata[0] == $past(|flag_reg[GRP_C_LSB +: CH_PER_GROUP])) &&
		(prdata[1] == $past(|flag_reg[GRP_D_LSB +: CH_PER_GROUP])) &&
		(prdata[2] == $past(|flag_reg[GRP_E_LSB +: CH_PER_GROUP])) &&
		(prdata[3] == $past(|flag_reg[GRP_F_LSB +: CH_PER_GROUP])))
		else $error("summary read wrong");

	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == '0) && !pslverr)
		else $error("response shown outside ready cycle");

	a_wr_no_data: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done |-> (prdata == '0))
		else $error("write returned read data");

	a_rd_inert: assert property (@(posedge pclk) disable iff (!presetn)
		rd_done |=> $stable(mask_reg) && $stable(latch_reg))
		else $error("read changed control state");

	a_unmapped_inert: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_done && !mapped) |=> $stable(mask_reg) && $stable(latch_reg))
		else $error("unmapped write had an effect");

	a_err_only_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(access_done && $past(mapped)) |-> !pslverr)
		else $error("mapped access answered with error");

endmodule

// ---- tb/single_led_short_flag_regs_tb.sv ----
module single_led_short_flag_regs_tb
	import short_flag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [ADDR_W-1:0]   paddr;
	logic [DATA_W-1:0]   pwdata;
	logic [STRB_W-1:0]   pstrb;
	short_detect_t       short_detect;
	logic [DATA_W-1:0]   prdata;
	logic                pready;
	logic                pslverr;
	int                  num_errors;
	int                  samples_checked;
	logic [31:0]         rng_state;
	short_detect_t       det;
	logic [ADDR_W-1:0]   flag_addr [3];

	short_led_flag_regs dut (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pstrb        (pstrb),
		.short_detect (short_detect),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		rng_state = rng_state ^ (rng_state << 13);
		rng_state = rng_state ^ (rng_state >> 17);
		rng_state = rng_state ^ (rng_state << 5);
		return rng_state;
	endfunction

	// two groups per byte, bits 7 and 3 always zero
	function automatic logic [DATA_W-1:0] exp_pair(input logic [2:0] hi, input logic [2:0] lo);
		return {24'h000000, 1'b0, hi, 1'b0, lo};
	endfunction

	// summary: one bit per group, set when any channel of it is flagged
	function automatic logic [DATA_W-1:0] exp_sum(input short_detect_t s);
		return {28'h0000000, |s.grp_f, |s.grp_e, |s.grp_d, |s.grp_c};
	endfunction

	task automatic tally_and_finish();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// request held until pready is seen high; no wait-state count assumed
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
			output logic [DATA_W-1:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			$display("[ERR] pready expected 1 seen timeout");
		end
	endtask

	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] rd;
		logic              err;
		apb(1'b0, a, 32'h00000000, rd, err);
		check(name, exp, rd);
		check({name, "_err"}, 32'h00000000, {31'h00000000, err});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		#100us;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		logic [DATA_W-1:0] rd;
		logic              err;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		short_detect = '0;
		num_errors = 0;
		samples_checked = 0;
		rng_state = 32'h00000039;
		flag_addr = '{ADDR_FLAGS_CD, ADDR_FLAGS_EF, ADDR_FLAGS_GH};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("cd_reset", ADDR_FLAGS_CD, 32'h00000000);
		rd_chk("ef_reset", ADDR_FLAGS_EF, 32'h00000000);
		rd_chk("gh_reset", ADDR_FLAGS_GH, 32'h00000000);
		// all-set and all-clear corners first, then random patterns
		for (int i = 0; i < 24; i++) begin
			det = (i == 0) ? short_detect_t'(12'hFFF) : (i == 1) ? short_detect_t'(12'h000) :
			      short_detect_t'(NUM_FLAGS'(xs()));
			short_detect <= det;
			// synchroniser plus flag register, one spare edge
			repeat (4) @(posedge pclk);
			rd_chk("cd_flags", ADDR_FLAGS_CD, exp_pair(det.grp_d, det.grp_c));
			rd_chk("ef_flags", ADDR_FLAGS_EF, exp_pair(det.grp_f, det.grp_e));
			rd_chk("gh_flags", ADDR_FLAGS_GH, 32'h00000000);
		end
		// writes to read-only flags must leave them unchanged
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, flag_addr[k], ~xs(), rd, err);
			check("ro_write_err", 32'h00000000, {31'h00000000, err});
		end
		rd_chk("cd_after_wr", ADDR_FLAGS_CD, exp_pair(det.grp_d, det.grp_c));
		rd_chk("ef_after_wr", ADDR_FLAGS_EF, exp_pair(det.grp_f, det.grp_e));
		// mask off group c, then latch, strobe-less write and clear
		apb(1'b1, ADDR_MASK, 32'h00000FF8, rd, err);
		rd_chk("mask_rb", ADDR_MASK, 32'h00000FF8);
		short_detect <= short_detect_t'(12'h0A5);
		det = short_detect_t'(12'h0A5 & 12'hFF8);
		repeat (4) @(posedge pclk);
		rd_chk("cd_masked", ADDR_FLAGS_CD, exp_pair(det.grp_d, det.grp_c));
		apb(1'b1, ADDR_CTRL, 32'h00000001, rd, err);
		short_detect <= '0;
		repeat (4) @(posedge pclk);
		rd_chk("cd_latched", ADDR_FLAGS_CD, exp_pair(det.grp_d, det.grp_c));
		rd_chk("ef_latched", ADDR_FLAGS_EF, exp_pair(det.grp_f, det.grp_e));
		rd_chk("summary", ADDR_SUMMARY, exp_sum(det));
		pstrb <= 4'h0;
		apb(1'b1, ADDR_CTRL, 32'h00000000, rd, err);
		pstrb <= 4'hF;
		rd_chk("ctrl_no_strb", ADDR_CTRL, 32'h00000001);
		apb(1'b1, ADDR_CTRL, 32'h00000003, rd, err);
		rd_chk("cd_cleared", ADDR_FLAGS_CD, 32'h00000000);
		rd_chk("ef_cleared", ADDR_FLAGS_EF, 32'h00000000);
		// latch a flag again, then reset mid-run: everything back to reset values
		short_detect <= short_detect_t'(12'h0A5);
		repeat (4) @(posedge pclk);
		short_detect <= '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("cd_rst2", ADDR_FLAGS_CD, 32'h00000000);
		rd_chk("ef_rst2", ADDR_FLAGS_EF, 32'h00000000);
		rd_chk("ctrl_rst2", ADDR_CTRL, 32'h00000000);
		rd_chk("mask_rst2", ADDR_MASK, 32'h00000FFF);
		apb(1'b0, 12'hFFC, 32'h00000000, rd, err);
		check("unmapped_err", 32'h00000001, {31'h00000000, err});
		check("unmapped_data", 32'h00000000, rd);
		apb(1'b1, 12'hFFC, 32'h00000FFF, rd, err);
		check("unmapped_wr_err", 32'h00000001, {31'h00000000, err});
		apb(1'b0, ADDR_FLAGS_CD + 12'h001, 32'h00000000, rd, err);
		check("misaligned_err", 32'h00000001, {31'h00000000, err});
		tally_and_finish();
	end
endmodule
